// [slvm_pkg.sv]
// package of the supply low voltage monitor: offsets, field positions, resets, types
// assumes a 32-bit AHB-Lite register bus and a 25 MHz system clock
package slvm_pkg;

	// ----------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] SLVM_STATUS_OFS = 8'h00;
	localparam logic [7:0] SLVM_CONFIG_OFS = 8'h04;
	localparam logic [7:0] SLVM_EVT_OFS = 8'h08;
	localparam logic [7:0] SLVM_MASK_OFS = 8'h0C;

	// ----------------------------------------
	// status/control field positions
	// ----------------------------------------
	localparam int SLVM_OUT_BIT = 7;
	localparam int SLVM_IE_BIT = 3;
	localparam int SLVM_IF_BIT = 2;
	localparam int SLVM_ACK_BIT = 1;

	// ----------------------------------------
	// configuration field positions
	// ----------------------------------------
	localparam int SLVM_PWROFF_BIT = 0;
	localparam int SLVM_RSTOFF_BIT = 1;
	localparam int SLVM_STOPON_BIT = 2;
	localparam int SLVM_SEL_LSB = 4;

	// ----------------------------------------
	// event bits and reset values
	// ----------------------------------------
	localparam int SLVM_EVT_TOGGLE = 0;
	localparam int SLVM_EVT_RESET = 1;
	localparam int SLVM_NEVT = 2;
	localparam logic [7:0] SLVM_CONFIG_RST = 8'h03;
	localparam logic [1:0] SLVM_SEL_RST = 2'h0;
	localparam logic [1:0] SLVM_SEL_3V3 = 2'h1;
	localparam int SLVM_SYNC_STAGES = 3;

	typedef enum logic [1:0] {
		SLVM_LVL_5V0,
		SLVM_LVL_3V3
	} slvm_level_t;

	// comparator pair from the analog macro
	typedef struct packed {
		logic below_fall;
		logic above_rise;
	} slvm_cmp_t;

	// low-power mode status from the clock controller
	typedef struct packed {
		logic wait_mode;
		logic stop_mode;
	} slvm_pwr_t;

endpackage

// [slvm_sync.sv]
// three-stage synchroniser with agreement filter
// assumes asynchronous inputs; output changes once stages two and three agree
`timescale 1ns/100ps
module slvm_sync #(
	parameter int WIDTH = 2
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// data
	input wire logic [WIDTH-1:0] d_async,
	output logic [WIDTH-1:0] q
);
	import slvm_pkg::*;

	logic [WIDTH-1:0] s1_r;
	logic [WIDTH-1:0] s2_r;
	logic [WIDTH-1:0] s3_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
		end else begin
			s1_r <= d_async;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_agree
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					q[i] <= 1'b0;
				end else if (s2_r[i] == s3_r[i]) begin
					q[i] <= s3_r[i];
				end
			end
		end
	endgenerate
endmodule

// [slvm_ahb.sv]
// AHB-Lite slave front end: registers the address phase, answers OKAY with no wait
// assumes single word transfers; unmapped addresses read zero and ignore writes
`timescale 1ns/100ps
module slvm_ahb (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	// register side
	output logic wr_en,
	output logic rd_en,
	output logic [7:0] addr
);
	import slvm_pkg::*;

	logic act_r;
	logic wr_r;
	logic [7:0] addr_r;
	logic take;

	assign take = hsel && hready && htrans[1] && (hsize == 3'h2);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			act_r <= 1'b0;
			wr_r <= 1'b0;
			addr_r <= 8'h00;
		end else begin
			act_r <= take;
			wr_r <= take && hwrite;
			if (take) begin
				addr_r <= haddr[7:0];
			end
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign wr_en = act_r && wr_r;
	assign rd_en = take && !hwrite;
	assign addr = addr_r;
endmodule

// [slvm_top.sv]
// supply low voltage monitor: indicator with hysteresis, toggle interrupt, forced reset
// assumes an analog comparator pair and a system reset controller outside
`timescale 1ns/100ps

module slvm_top (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// analog comparator and power mode
	input wire slvm_pkg::slvm_cmp_t cmp_async,
	input wire slvm_pkg::slvm_pwr_t pwr,
	output logic monitor_enable,
	output logic [1:0] trip_level_select,
	// system side
	output logic lowv_irq,
	output logic event_irq,
	output logic sys_reset_req,
	output logic wake_req,
	output logic reset_pin_n_o,
	output logic reset_pin_oe_n
);
	import slvm_pkg::*;

	// ----------------------------------------
	// reset release
	// ----------------------------------------
	logic [1:0] rst_sync_r;
	logic rst_n;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_sync_r <= 2'b00;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_r[1];

	// ----------------------------------------
	// bus front end
	// ----------------------------------------
	logic wr_en;
	logic rd_en;
	logic [7:0] addr;

	slvm_ahb slvm_ahb_i (
		.clk(clk),
		.rst_n(rst_n),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hready(hready),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.wr_en(wr_en),
		.rd_en(rd_en),
		.addr(addr)
	);

	function automatic logic hit(input logic en, input logic [7:0] a, input logic [7:0] ofs);
		hit = en && (a == ofs);
	endfunction

	// ----------------------------------------
	// register decode
	// ----------------------------------------
	logic wr_status;
	logic wr_config;
	logic wr_evt;
	logic wr_mask;
	logic rd_status;
	logic rd_config;
	logic rd_evt;
	logic rd_mask;

	// writes use the registered address phase, reads the live one
	assign wr_status = hit(wr_en, addr, SLVM_STATUS_OFS);
	assign wr_config = hit(wr_en, addr, SLVM_CONFIG_OFS);
	assign wr_evt = hit(wr_en, addr, SLVM_EVT_OFS);
	assign wr_mask = hit(wr_en, addr, SLVM_MASK_OFS);
	assign rd_status = hit(rd_en, haddr[7:0], SLVM_STATUS_OFS);
	assign rd_config = hit(rd_en, haddr[7:0], SLVM_CONFIG_OFS);
	assign rd_evt = hit(rd_en, haddr[7:0], SLVM_EVT_OFS);
	assign rd_mask = hit(rd_en, haddr[7:0], SLVM_MASK_OFS);

	// ----------------------------------------
	// comparator synchroniser
	// ----------------------------------------
	logic [1:0] cmp_s;
	slvm_cmp_t cmp;

	slvm_sync #(
		.WIDTH(2)
	) slvm_sync_i (
		.clk(clk),
		.rst_n(rst_n),
		.d_async(cmp_async),
		.q(cmp_s)
	);
	assign cmp = slvm_cmp_t'(cmp_s);

	// ----------------------------------------
	// configuration
	// ----------------------------------------
	logic pwr_off_r;
	logic rst_off_r;
	logic stop_on_r;
	logic [1:0] sel_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pwr_off_r <= SLVM_CONFIG_RST[SLVM_PWROFF_BIT];
			rst_off_r <= SLVM_CONFIG_RST[SLVM_RSTOFF_BIT];
			stop_on_r <= SLVM_CONFIG_RST[SLVM_STOPON_BIT];
			sel_r <= SLVM_SEL_RST;
		end else if (wr_config) begin
			pwr_off_r <= hwdata[SLVM_PWROFF_BIT];
			rst_off_r <= hwdata[SLVM_RSTOFF_BIT];
			stop_on_r <= hwdata[SLVM_STOPON_BIT];
			sel_r <= hwdata[SLVM_SEL_LSB +: 2];
		end
	end

	// ----------------------------------------
	// active gating by mode
	// ----------------------------------------
	logic active;
	logic rst_gen;

	// wait keeps it running, stop only with keep-on
	assign active = !pwr_off_r && (!pwr.stop_mode || stop_on_r);
	assign rst_gen = active && !rst_off_r;
	assign monitor_enable = active;
	assign trip_level_select = sel_r;

	// ----------------------------------------
	// below-trip indicator
	// ----------------------------------------
	logic out_r;
	logic out_nxt;

	always_comb begin
		out_nxt = out_r;
		if (active) begin
			if (cmp.below_fall) begin
				out_nxt = 1'b1;
			end else if (cmp.above_rise) begin
				out_nxt = 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_r <= 1'b0;
		end else begin
			out_r <= out_nxt;
		end
	end

	// ----------------------------------------
	// forced low supply reset
	// ----------------------------------------
	logic hold_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hold_r <= 1'b0;
		end else if (rst_gen && cmp.below_fall) begin
			hold_r <= 1'b1;
		end else if (cmp.above_rise) begin
			hold_r <= 1'b0;
		end
	end
	// hold survives the system reset it causes; above_rise or reset clears it
	assign sys_reset_req = hold_r;
	assign reset_pin_n_o = 1'b0;
	assign reset_pin_oe_n = !hold_r;

	// ----------------------------------------
	// toggle flag, enable and ack
	// ----------------------------------------
	logic if_r;
	logic ie_r;
	logic toggle;
	logic ack;

	assign toggle = (out_nxt != out_r) && rst_off_r;
	assign ack = wr_status && hwdata[SLVM_ACK_BIT];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			if_r <= 1'b0;
		end else if (toggle) begin
			if_r <= 1'b1;
		end else if (ack) begin
			if_r <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ie_r <= 1'b0;
		end else if (hold_r && !rst_off_r) begin
			ie_r <= 1'b0;
		end else if (wr_status) begin
			ie_r <= hwdata[SLVM_IE_BIT];
		end
	end

	assign lowv_irq = if_r && ie_r && rst_off_r;
	assign wake_req = (lowv_irq || hold_r) && active;

	// ----------------------------------------
	// event status and mask
	// ----------------------------------------
	logic [SLVM_NEVT-1:0] evt_r;
	logic [SLVM_NEVT-1:0] mask_r;
	logic [SLVM_NEVT-1:0] evt_set;
	logic hold_d_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hold_d_r <= 1'b0;
		end else begin
			hold_d_r <= hold_r;
		end
	end

	always_comb begin
		evt_set = '0;
		evt_set[SLVM_EVT_TOGGLE] = toggle;
		evt_set[SLVM_EVT_RESET] = hold_r && !hold_d_r;
	end

	genvar e;
	generate
		for (e = 0; e < SLVM_NEVT; e++) begin : g_evt
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					evt_r[e] <= 1'b0;
				end else if (evt_set[e]) begin
					evt_r[e] <= 1'b1;
				end else if (wr_evt && hwdata[e]) begin
					evt_r[e] <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mask_r <= '0;
		end else if (wr_mask) begin
			mask_r <= hwdata[SLVM_NEVT-1:0];
		end
	end

	assign event_irq = |(evt_r & mask_r);

	// ----------------------------------------
	// read data
	// ----------------------------------------
	logic [31:0] rd_nxt;

	always_comb begin
		rd_nxt = 32'h0000_0000;
		if (rd_status) begin
			rd_nxt[SLVM_OUT_BIT] = out_r;
			rd_nxt[SLVM_IE_BIT] = ie_r;
			rd_nxt[SLVM_IF_BIT] = if_r; // ack bit stays zero
		end else if (rd_config) begin
			rd_nxt[SLVM_PWROFF_BIT] = pwr_off_r;
			rd_nxt[SLVM_RSTOFF_BIT] = rst_off_r;
			rd_nxt[SLVM_STOPON_BIT] = stop_on_r;
			rd_nxt[SLVM_SEL_LSB +: 2] = sel_r;
		end else if (rd_evt) begin
			rd_nxt[SLVM_NEVT-1:0] = evt_r;
		end else if (rd_mask) begin
			rd_nxt[SLVM_NEVT-1:0] = mask_r;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hrdata <= 32'h0000_0000;
		end else if (rd_en) begin
			hrdata <= rd_nxt;
		end
	end
endmodule

// [slvm_asserts.sv]
// port checker of the supply low voltage monitor
// assumes binding to slvm_top; comparator levels are asynchronous
`timescale 1ns/100ps
module slvm_asserts (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// watched ports
	input wire logic hreadyout,
	input wire logic hresp,
	input wire slvm_pkg::slvm_cmp_t cmp_async,
	input wire logic monitor_enable,
	input wire logic lowv_irq,
	input wire logic sys_reset_req,
	input wire logic wake_req,
	input wire logic reset_pin_n_o,
	input wire logic reset_pin_oe_n
);
	import slvm_pkg::*;
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	sequence s_rise_absent;
		!cmp_async.above_rise [*6];
	endsequence
	property p_bus;
		hreadyout && !hresp;
	endproperty
	property p_start;
		$rose(arst_n) |-> !monitor_enable [*3];
	endproperty
	property p_hold;
		s_rise_absent ##0 sys_reset_req |=> sys_reset_req;
	endproperty
	property p_sync;
		$rose(sys_reset_req) |-> $past(cmp_async.below_fall, 3) && monitor_enable;
	endproperty
	property p_release;
		$fell(sys_reset_req) |-> $past(cmp_async.above_rise, 3);
	endproperty
	property p_pin;
		reset_pin_oe_n == !sys_reset_req && !reset_pin_n_o;
	endproperty
	property p_prio;
		sys_reset_req |-> !lowv_irq;
	endproperty
	property p_wake;
		wake_req == ((lowv_irq || sys_reset_req) && monitor_enable);
	endproperty
	a_bus: assert property (p_bus) else $error("bus not ready or not okay");
	a_start: assert property (p_start) else $error("monitor on after reset");
	a_hold: assert property (p_hold) else $error("reset left while low");
	a_sync: assert property (p_sync) else $error("reset without synced drop");
	a_release: assert property (p_release) else $error("reset left below rise");
	a_pin: assert property (p_pin) else $error("reset pin wrong");
	a_prio: assert property (p_prio) else $error("irq during reset");
	a_wake: assert property (p_wake) else $error("wake without event");
endmodule

bind slvm_top slvm_asserts slvm_asserts_i (.clk(clk), .arst_n(arst_n), .hreadyout(hreadyout),
	.hresp(hresp), .cmp_async(cmp_async), .monitor_enable(monitor_enable), .lowv_irq(lowv_irq),
	.sys_reset_req(sys_reset_req), .wake_req(wake_req), .reset_pin_n_o(reset_pin_n_o),
	.reset_pin_oe_n(reset_pin_oe_n));

// [slvm_cmp_model.sv]
// comparator pair model for the monitor bench
// assumes a commanded supply zone: 0 below fall, 1 between levels, 2 above rise
`timescale 1ns/100ps
module slvm_cmp_model (
	// command
	input wire logic [1:0] zone,
	input wire logic powered,
	// comparator
	output slvm_pkg::slvm_cmp_t cmp
);
	import slvm_pkg::*;
	// unpowered comparator reports no level
	always_comb begin
		cmp.below_fall = powered && zone == 2'h0;
		cmp.above_rise = powered && zone == 2'h2;
	end
endmodule

// [slvm_top_tb.sv]
// bench of the supply low voltage monitor: AHB-Lite register tests
// assumes slvm_top, slvm_cmp_model and the bound checker
`timescale 1ns/100ps
module slvm_top_tb;
	import slvm_pkg::*;
	localparam logic [31:0] OUT = 32'h1 << SLVM_OUT_BIT;
	localparam logic [31:0] IE = 32'h1 << SLVM_IE_BIT;
	localparam logic [31:0] IFL = 32'h1 << SLVM_IF_BIT;
	localparam logic [31:0] ACK = 32'h1 << SLVM_ACK_BIT;
	localparam logic [31:0] RSTOFF = 32'h1 << SLVM_RSTOFF_BIT;
	localparam logic [31:0] SEL3 = 32'(SLVM_SEL_3V3) << SLVM_SEL_LSB;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0] zone = 2'h2;
	slvm_pwr_t pwr = '0;
	slvm_cmp_t cmp;
	logic hreadyout, hresp, mon_en, lowv_irq, event_irq, sys_rst, wake_req, pin_o, pin_oe_n;
	logic [1:0] tls;
	logic [31:0] hrdata, rd;
	int fail_count = 0;
	int samples_checked = 0;
	int cycles = 0;
	always #20 clk = ~clk;
	slvm_top slvm_top_i (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cmp_async(cmp), .pwr(pwr),
		.monitor_enable(mon_en), .trip_level_select(tls), .lowv_irq(lowv_irq),
		.event_irq(event_irq), .sys_reset_req(sys_rst), .wake_req(wake_req),
		.reset_pin_n_o(pin_o), .reset_pin_oe_n(pin_oe_n));
	slvm_cmp_model slvm_cmp_model_i (.zone(zone), .powered(mon_en), .cmp(cmp));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		if (fail_count == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check(rd, exp);
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			tally_and_finish();
		end
	end
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		wt(20);
		arst_n <= 1'b1;
		wt(3);
		rchk(SLVM_STATUS_OFS, 32'h0);
		rchk(SLVM_CONFIG_OFS, {24'h0, SLVM_CONFIG_RST});
		check(mon_en, 1'b0);
		bus(1'b1, SLVM_CONFIG_OFS, 32'h3);
		bus(1'b1, SLVM_CONFIG_OFS, RSTOFF);
		bus(1'b1, SLVM_STATUS_OFS, IE);
		bus(1'b1, SLVM_MASK_OFS, 32'h1);
		wt(8);
		check(mon_en, 1'b1);
		zone <= 2'h0;
		wt(8);
		rchk(SLVM_STATUS_OFS, OUT | IE | IFL);
		check(lowv_irq, 1'b1);
		check(event_irq, 1'b1);
		check(sys_rst, 1'b0);
		bus(1'b1, SLVM_MASK_OFS, 32'h0);
		wt(2);
		check(event_irq, 1'b0);
		bus(1'b1, SLVM_EVT_OFS, 32'h1);
		bus(1'b1, SLVM_MASK_OFS, 32'h1);
		rchk(SLVM_EVT_OFS, 32'h0);
		check(event_irq, 1'b0);
		bus(1'b1, SLVM_STATUS_OFS, IE);
		rchk(SLVM_STATUS_OFS, OUT | IE | IFL);
		bus(1'b1, SLVM_STATUS_OFS, IE | ACK);
		rchk(SLVM_STATUS_OFS, OUT | IE);
		check(lowv_irq, 1'b0);
		zone <= 2'h1;
		wt(8);
		rchk(SLVM_STATUS_OFS, OUT | IE);
		zone <= 2'h2;
		wt(8);
		rchk(SLVM_STATUS_OFS, IE | IFL);
		bus(1'b1, SLVM_STATUS_OFS, IE | ACK);
		pwr.wait_mode <= 1'b1;
		zone <= 2'h0;
		wt(8);
		check(wake_req, 1'b1);
		pwr <= '{wait_mode: 1'b0, stop_mode: 1'b1};
		bus(1'b1, SLVM_STATUS_OFS, IE | ACK);
		zone <= 2'h2;
		wt(8);
		rchk(SLVM_STATUS_OFS, OUT | IE);
		check(wake_req, 1'b0);
		bus(1'b1, SLVM_CONFIG_OFS, RSTOFF | 32'h4);
		wt(8);
		rchk(SLVM_STATUS_OFS, IE | IFL);
		check(wake_req, 1'b1);
		pwr <= '0;
		bus(1'b1, SLVM_STATUS_OFS, IE | ACK);
		bus(1'b1, SLVM_EVT_OFS, 32'h3);
		bus(1'b1, SLVM_CONFIG_OFS, 32'h0);
		zone <= 2'h0;
		wt(8);
		check(sys_rst, 1'b1);
		check(pin_oe_n, 1'b0);
		check(lowv_irq, 1'b0);
		rchk(SLVM_STATUS_OFS, OUT);
		rchk(SLVM_EVT_OFS, 32'h2);
		zone <= 2'h1;
		wt(8);
		check(sys_rst, 1'b1);
		zone <= 2'h2;
		wt(8);
		check(sys_rst, 1'b0);
		check(pin_oe_n, 1'b1);
		bus(1'b1, SLVM_CONFIG_OFS, SEL3 | 32'h1);
		zone <= 2'h0;
		wt(4);
		bus(1'b1, SLVM_CONFIG_OFS, SEL3);
		wt(8);
		check(tls, SLVM_SEL_3V3);
		check(sys_rst, 1'b1);
		zone <= 2'h2;
		wt(8);
		check(sys_rst, 1'b0);
		rchk(8'h40, 32'h0);
		bus(1'b1, SLVM_STATUS_OFS, IE);
		rchk(SLVM_STATUS_OFS, IE);
		arst_n <= 1'b0;
		wt(2);
		arst_n <= 1'b1;
		wt(3);
		rchk(SLVM_STATUS_OFS, 32'h0);
		rchk(SLVM_CONFIG_OFS, {24'h0, SLVM_CONFIG_RST});
		check(mon_en, 1'b0);
		check(sys_rst, 1'b0);
		tally_and_finish();
	end
endmodule
